/* design/stir_pkg.sv */
/*
 * constants for the spectral threshold and interrupt register block:
 * register offsets, field positions, reset values, identifier values.
 * assumes an 8-bit register port addressed by the device's own 8-bit offsets.
 */
package stir_pkg;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_LO_TH_LO = 8'h84;
    localparam logic [7:0] OFS_LO_TH_HI = 8'h85;
    localparam logic [7:0] OFS_HI_TH_LO = 8'h86;
    localparam logic [7:0] OFS_HI_TH_HI = 8'h87;
    localparam logic [7:0] OFS_AUX_ID = 8'h90;
    localparam logic [7:0] OFS_REVISION_NUMBER = 8'h91;
    localparam logic [7:0] OFS_PART_ID = 8'h92;
    localparam logic [7:0] OFS_STATUS = 8'h93;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int AUX_ID_MSB = 3;
    localparam int REVISION_NUMBER_MSB = 2;
    localparam int PART_ID_LSB = 2;
    localparam int STATUS_EVENT_BIT = 3;
    // ---------------------------------------------------------------
    // reset values and identifiers (identifier values are arbitrary)
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_TH = 16'h0000;
    localparam logic [3:0] AUX_ID_VAL = 4'h5;
    localparam logic [2:0] REVISION_NUMBER_VAL = 3'h2;
    localparam logic [5:0] PART_ID_VAL = 6'h2a;
    localparam logic [7:0] RST_PERSIST = 8'h00;
endpackage

/* design/stir_regs.sv */
/*
 * spectral threshold register bank with out-of-window persistence event.
 * assumes a single-cycle register port on clk (wr_en/rd_en with address),
 * and channel-zero results arriving as a one-cycle valid strobe on clk.
 */
// Contract
// R01: the three identifier registers are read only and ignore writes.
// R02: auxiliary id sits in bits 3:0, revision in 2:0, part number in 7:2, rest reads zero.
// R03: one 16-bit low and one 16-bit high threshold are compared with the channel-zero result.
// R04: with the enable set, the event is raised after the set number of consecutive misses.
// R05: a result below the low threshold counts as out of window.
// R06: a result above the high threshold counts as out of window.
// R07: the low threshold's low byte waits in a holding latch until its high byte is written.
// R08: the host writes the high byte after the low byte, ideally in one transaction.
// R09: low threshold bytes sit at 0x84 and 0x85, read-write, reset to zero.
// R10: high threshold bytes sit at 0x86 and 0x87, read-write, reset to zero.
// R11: status bit 3 holds the event; writing one clears it, zero leaves it.
// R12: the high threshold uses the same holding latch scheme as the low one.
`timescale 1ns/1ns
module stir_regs
    import stir_pkg::*;
#(
    parameter int PERS_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic spectral_interrupt_enable,
    input wire logic [PERS_W-1:0] spectral_persistence_count,
    input wire logic [15:0] channel_zero_result,
    input wire logic result_valid,
    output logic spectral_threshold_event_flag,
    output logic [15:0] low_threshold,
    output logic [15:0] high_threshold
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] lo_lo_latch_ff;
    logic [7:0] hi_lo_latch_ff;
    logic [15:0] lo_th_ff;
    logic [15:0] hi_th_ff;
    logic [PERS_W-1:0] miss_cnt_ff;
    logic [PERS_W-1:0] nxt_miss_cnt;
    logic event_ff;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic [7:0] nxt_rd_data;
    logic out_of_window;
    logic hit_pers;
    logic clr_event;

    // write strobe decode for one offset
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic we);
        wr_hit = we && (a == ofs);
    endfunction

    // ---------------------------------------------------------------
    // threshold registers
    // ---------------------------------------------------------------
    // low bytes wait in latches; the 16-bit value moves only on a high byte write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lo_lo_latch_ff <= RST_BYTE;
            lo_th_ff <= RST_TH;
        end else begin
            if (wr_hit(addr, OFS_LO_TH_LO, wr_en)) begin
                lo_lo_latch_ff <= wr_data; // R07 R09
            end
            if (wr_hit(addr, OFS_LO_TH_HI, wr_en)) begin
                lo_th_ff <= {wr_data, lo_lo_latch_ff}; // R07 R09
            end
        end
    end

    // high threshold pair handled the same way
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_lo_latch_ff <= RST_BYTE;
            hi_th_ff <= RST_TH;
        end else begin
            if (wr_hit(addr, OFS_HI_TH_LO, wr_en)) begin
                hi_lo_latch_ff <= wr_data; // R12 R10
            end
            if (wr_hit(addr, OFS_HI_TH_HI, wr_en)) begin
                hi_th_ff <= {wr_data, hi_lo_latch_ff}; // R12 R10
            end
        end
    end

    // ---------------------------------------------------------------
    // window compare and persistence
    // ---------------------------------------------------------------
    // strict compares against the applied thresholds
    assign out_of_window = (channel_zero_result < lo_th_ff) // R03 R05
                        || (channel_zero_result > hi_th_ff); // R06
    assign hit_pers = (nxt_miss_cnt >= spectral_persistence_count) && out_of_window;
    assign clr_event = wr_hit(addr, OFS_STATUS, wr_en) && wr_data[STATUS_EVENT_BIT];

    // consecutive miss count saturates, any in-window result restarts it
    always_comb begin
        nxt_miss_cnt = miss_cnt_ff;
        if (result_valid) begin
            if (!out_of_window) begin
                nxt_miss_cnt = '0;
            end else if (miss_cnt_ff != '1) begin
                nxt_miss_cnt = miss_cnt_ff + 1'b1; // R04
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            miss_cnt_ff <= RST_PERSIST[PERS_W-1:0];
        end else begin
            miss_cnt_ff <= nxt_miss_cnt;
        end
    end

    // sticky event; a new event wins over a same-cycle clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            event_ff <= 1'b0;
        end else if (result_valid && spectral_interrupt_enable && hit_pers) begin
            event_ff <= 1'b1; // R04
        end else if (clr_event) begin
            event_ff <= 1'b0; // R11
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    // identifiers are constants, so writes there have nothing to change
    always_comb begin
        nxt_rd_data = 8'h00;
        unique case (addr)
            OFS_LO_TH_LO: nxt_rd_data = lo_lo_latch_ff;
            OFS_LO_TH_HI: nxt_rd_data = lo_th_ff[15:8];
            OFS_HI_TH_LO: nxt_rd_data = hi_lo_latch_ff;
            OFS_HI_TH_HI: nxt_rd_data = hi_th_ff[15:8];
            OFS_AUX_ID: nxt_rd_data[AUX_ID_MSB:0] = AUX_ID_VAL; // R01 R02
            OFS_REVISION_NUMBER: nxt_rd_data[REVISION_NUMBER_MSB:0] = REVISION_NUMBER_VAL; // R01 R02
            OFS_PART_ID: nxt_rd_data[7:PART_ID_LSB] = PART_ID_VAL; // R01 R02
            OFS_STATUS: nxt_rd_data[STATUS_EVENT_BIT] = event_ff; // R11
            default: nxt_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign spectral_threshold_event_flag = event_ff;
    assign low_threshold = lo_th_ff;
    assign high_threshold = hi_th_ff;
endmodule // stir_regs

/* tb/stir_host.sv */
/* host model: register strobes from the falling edge; data inverted after release */
`timescale 1ns/1ns
module stir_host (
    input wire logic clk, output logic wr_en = 1'b0, output logic rd_en = 1'b0,
    output logic [7:0] addr = 8'h00, output logic [7:0] wr_data = 8'h00,
    input wire logic [7:0] rd_data
);
    // one write strobe held over one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    // threshold pair: low byte first, then high byte
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    // read strobe, data taken once the answer is registered
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        d = rd_data;
    endtask
endmodule // stir_host

/* tb/stir_regs_sva.sv */
/* port assertions for stir_regs; bound to every instance of it */
`timescale 1ns/1ns
module stir_regs_sva import stir_pkg::*; (
    input wire logic clk, input wire logic sys_rst, input wire logic wr_en,
    input wire logic rd_en, input wire logic [7:0] addr, input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data, input wire logic rd_valid, input wire logic result_valid,
    input wire logic spectral_interrupt_enable, input wire logic spectral_threshold_event_flag,
    input wire logic [15:0] low_threshold, input wire logic [15:0] high_threshold
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // decoded strobes: status clear, high-byte writes
    wire logic clr = wr_en && addr == OFS_STATUS && wr_data[STATUS_EVENT_BIT];
    wire logic wlh = wr_en && addr == OFS_LO_TH_HI;
    wire logic whh = wr_en && addr == OFS_HI_TH_HI;
    chk_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    chk_part_id: assert property (rd_en && addr == OFS_PART_ID |=> rd_data[7:2] == PART_ID_VAL)
        else $error("part id wrong");
    chk_lo_apply: assert property (wlh |=> low_threshold[15:8] == $past(wr_data))
        else $error("low threshold not applied");
    chk_lo_hold: assert property (!wlh |=> $stable(low_threshold))
        else $error("low threshold moved");
    chk_hi_apply: assert property (whh |=> high_threshold[15:8] == $past(wr_data))
        else $error("high threshold not applied");
    chk_flag_clear: assert property (clr && !result_valid |=> !spectral_threshold_event_flag)
        else $error("event not cleared");
    chk_flag_sticky: assert property (spectral_threshold_event_flag && !clr |=> spectral_threshold_event_flag)
        else $error("event dropped");
    chk_flag_cause: assert property ($rose(spectral_threshold_event_flag) |-> $past(result_valid))
        else $error("event without result");
endmodule // stir_regs_sva
bind stir_regs stir_regs_sva i_sva (.*);

/* tb/stir_regs_tb.sv */
/* bench for stir_regs: host model on the register port, results driven here */
`timescale 1ns/1ns
module stir_regs_tb import stir_pkg::*;;
    logic clk = 1'b0, sys_rst = 1'b1, en = 1'b0, rv = 1'b0, wr_en, rd_en, rd_valid, flag;
    logic [15:0] res = 16'h0000, lo, hi;
    logic [7:0] pers = 8'h02, d, addr, wr_data, rd_data;
    int num_errors = 0, checks_done = 0, cycles = 0;
    // rows: expected event in bit 16, result below
    logic [16:0] rows [7] = '{17'h0_1000, 17'h1_1000, 17'h0_5000, 17'h0_9000, 17'h0_1234,
        17'h0_9000, 17'h1_8001};
    always #5 clk = ~clk;
    stir_host i_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data));
    stir_regs #(.PERS_W(8)) i_dut (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .spectral_interrupt_enable(en), .spectral_persistence_count(pers),
        .channel_zero_result(res), .result_valid(rv), .spectral_threshold_event_flag(flag),
        .low_threshold(lo), .high_threshold(hi));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one measurement strobe
    task automatic meas(input logic [15:0] v);
        @(negedge clk);
        res = v;
        rv = 1'b1;
        @(negedge clk);
        rv = 1'b0;
        res = ~v;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        i_host.wr(OFS_PART_ID, 8'hff);
        for (int a = 0; a < 4; a++) begin
            i_host.rd(OFS_LO_TH_LO + a[7:0], d);
            check({8'h00, d}, {8'h00, RST_BYTE});
            check({15'h0000, rd_valid}, 16'h0001);
        end
        i_host.rd(OFS_AUX_ID, d);
        check({8'h00, d}, {12'h000, AUX_ID_VAL});
        i_host.rd(OFS_REVISION_NUMBER, d);
        check({8'h00, d}, {13'h0000, REVISION_NUMBER_VAL});
        i_host.rd(OFS_PART_ID, d);
        check({8'h00, d}, {8'h00, PART_ID_VAL, 2'b00});
        i_host.rd(8'h80, d);
        check({8'h00, d}, 16'h0000);
        i_host.wr(OFS_LO_TH_LO, 8'h34);
        check(lo, RST_TH);
        i_host.wr(OFS_LO_TH_HI, 8'h12);
        check(lo, 16'h1234);
        i_host.rd(OFS_LO_TH_LO, d);
        check({8'h00, d}, 16'h0034);
        i_host.wr16(OFS_HI_TH_LO, 16'h8000);
        check(hi, 16'h8000);
        $display("registers test done");
        en = 1'b1;
        foreach (rows[i]) begin
            meas(rows[i][15:0]);
            check({15'h0000, flag}, {15'h0000, rows[i][16]});
            if (rows[i][16]) begin
                i_host.wr(OFS_STATUS, 8'h08);
                check({15'h0000, flag}, 16'h0000);
            end
        end
        en = 1'b0;
        meas(16'h0001);
        check({15'h0000, flag}, 16'h0000);
        en = 1'b1;
        meas(16'h0001);
        i_host.wr(OFS_STATUS, 8'h00);
        check({15'h0000, flag}, 16'h0001);
        $display("event test done");
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        check(lo, RST_TH);
        check({15'h0000, flag}, 16'h0000);
        $display("reset test done");
        report_and_stop();
    end
endmodule // stir_regs_tb
